// >>> hdl/lbc_pkg.sv
`default_nettype none
package lbc_pkg;
    // ************************************
    // Command decode and widths
    // ************************************
    localparam int NUM_BANKS = 4;
    localparam int TMR_W = 8;

    typedef enum logic [3:0] {
        CMD_DESELECT = 4'h0,
        CMD_NOP = 4'h1,
        CMD_ACTIVE = 4'h2,
        CMD_READ = 4'h3,
        CMD_WRITE = 4'h4,
        CMD_PRECHARGE = 4'h5,
        CMD_BURST_STOP = 4'h6,
        CMD_REFRESH = 4'h7,
        CMD_LOAD_MODE = 4'h8
    } lbc_cmd_t;

    typedef enum logic [2:0] {
        BK_IDLE = 3'b000,
        BK_ACTIVATING = 3'b001,
        BK_ROW_ACTIVE = 3'b010,
        BK_READ = 3'b011,
        BK_WRITE = 3'b100,
        BK_READ_AP = 3'b101,
        BK_WRITE_AP = 3'b110,
        BK_PRECHARGING = 3'b111
    } lbc_bank_state_t;

    typedef enum logic [1:0] {
        DEV_READY = 2'b00,
        DEV_REFRESHING = 2'b01,
        DEV_MODE_ACCESS = 2'b10,
        DEV_PRECHARGE_ALL = 2'b11
    } lbc_dev_state_t;

    // Command bus as sampled on the rising edge
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] bank;
        logic auto_pre;
        logic all_banks;
    } lbc_cmd_bus_t;

    // Per-bank view given back to the controller
    typedef struct packed {
        lbc_bank_state_t state;
        logic [TMR_W-1:0] timer;
    } lbc_bank_t;

    // ************************************
    // Timing, in ns and in cycles of 10 MHz
    // ************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_RP_NS = 15;
    localparam int T_RCD_NS = 15;
    localparam int T_RFC_NS = 72;
    localparam int T_MRD_NS = 10;
    localparam int T_WR_NS = 15;
    localparam int T_WTR_CK = 1;
    localparam int BURST_LEN = 4;
    localparam int CAS_LAT = 3;

    function automatic int ns_to_ck(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int RP_CK = ns_to_ck(T_RP_NS);
    localparam int RCD_CK = ns_to_ck(T_RCD_NS);
    localparam int RFC_CK = ns_to_ck(T_RFC_NS);
    localparam int MRD_CK = ns_to_ck(T_MRD_NS);
    localparam int WR_CK = ns_to_ck(T_WR_NS);
    localparam int RESET_TIMER = 0;
endpackage : lbc_pkg
`default_nettype wire

// >>> hdl/lbc_cmd_decode.sv
`default_nettype none
module lbc_cmd_decode
    import lbc_pkg::*;
(
    input wire lbc_pkg::lbc_cmd_bus_t bus,
    output lbc_pkg::lbc_cmd_t cmd
);
    always_comb
    begin
        if (bus.cs_n)
            cmd = CMD_DESELECT;
        else
        begin
            case ({bus.ras_n, bus.cas_n, bus.we_n})
                3'b111: cmd = CMD_NOP;
                3'b011: cmd = CMD_ACTIVE;
                3'b101: cmd = CMD_READ;
                3'b100: cmd = CMD_WRITE;
                3'b010: cmd = CMD_PRECHARGE;
                3'b110: cmd = CMD_BURST_STOP;
                3'b001: cmd = CMD_REFRESH;
                3'b000: cmd = CMD_LOAD_MODE;
                default: cmd = CMD_NOP;
            endcase
        end
    end
endmodule // lbc_cmd_decode
`default_nettype wire

// >>> hdl/lbc_bank_legality.sv
`default_nettype none
module lbc_bank_legality
    import lbc_pkg::*;
#(
    parameter int BL = BURST_LEN,
    parameter int CL = CAS_LAT
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire lbc_pkg::lbc_cmd_bus_t cmd_bus,
    output lbc_pkg::lbc_bank_t bank_view [lbc_pkg::NUM_BANKS],
    output lbc_pkg::lbc_dev_state_t dev_state,
    output logic all_idle,
    output logic cmd_illegal,
    output logic cmd_accepted
);
    import lbc_pkg::*;

    localparam logic [TMR_W-1:0] BURST_CK = TMR_W'(BL / 2);
    localparam logic [TMR_W-1:0] RP_T = TMR_W'(RP_CK);
    localparam logic [TMR_W-1:0] RCD_T = TMR_W'(RCD_CK);
    localparam logic [TMR_W-1:0] RFC_T = TMR_W'(RFC_CK);
    localparam logic [TMR_W-1:0] MRD_T = TMR_W'(MRD_CK);
    localparam logic [TMR_W-1:0] WR_T = TMR_W'(WR_CK);
    localparam logic [TMR_W-1:0] WTR_T = TMR_W'(T_WTR_CK);
    localparam logic [TMR_W-1:0] CL_T = TMR_W'(CL);
    localparam logic [TMR_W-1:0] ONE_T = TMR_W'(1);

    // ************************************
    // State
    // ************************************
    typedef struct packed {
        lbc_bank_state_t [NUM_BANKS-1:0] st;
        logic [NUM_BANKS-1:0][TMR_W-1:0] tmr;
        // Access period still running for auto precharge banks
        logic [NUM_BANKS-1:0][TMR_W-1:0] acc;
        lbc_dev_state_t dev;
        logic [TMR_W-1:0] dev_tmr;
        // Earliest-issue gaps for other-bank commands after AP commands
        logic [TMR_W-1:0] gap_rd;
        logic [TMR_W-1:0] gap_wr;
        logic [TMR_W-1:0] gap_pa;
        logic [1:0] last_rd_bank;
        logic rd_live;
        logic cke_prev;
        logic illegal;
        logic accepted;
    } lbc_state_t;

    lbc_state_t cur;
    lbc_state_t next_cur;
    lbc_cmd_t cmd;

    lbc_cmd_decode u_decode
    (
        .bus(cmd_bus),
        .cmd(cmd)
    );

    function automatic logic [TMR_W-1:0] dec(input logic [TMR_W-1:0] v);
        return (v == '0) ? v : v - ONE_T;
    endfunction

    function automatic logic [TMR_W-1:0] maxt(input logic [TMR_W-1:0] a,
                                              input logic [TMR_W-1:0] b);
        return (a > b) ? a : b;
    endfunction

    always_comb
    begin
        logic [1:0] b;
        logic ok;
        logic any_busy;
        next_cur = cur;
        b = cmd_bus.bank;
        ok = 1'b1;
        any_busy = 1'b0;
        next_cur.cke_prev = cmd_bus.cke;
        next_cur.dev_tmr = dec(cur.dev_tmr);
        next_cur.gap_rd = dec(cur.gap_rd);
        next_cur.gap_wr = dec(cur.gap_wr);
        next_cur.gap_pa = dec(cur.gap_pa);

        // ************************************
        // Timer-driven bank transitions
        // ************************************
        for (int i = 0; i < NUM_BANKS; i++)
        begin
            next_cur.tmr[i] = dec(cur.tmr[i]);
            next_cur.acc[i] = dec(cur.acc[i]);
            if (cur.st[i] != BK_IDLE)
                any_busy = 1'b1;
            if (cur.tmr[i] <= ONE_T)
            begin
                case (cur.st[i])
                    BK_ACTIVATING: next_cur.st[i] = BK_ROW_ACTIVE;
                    BK_PRECHARGING: next_cur.st[i] = BK_IDLE;
                    BK_READ, BK_WRITE: next_cur.st[i] = BK_ROW_ACTIVE;
                    BK_READ_AP, BK_WRITE_AP: next_cur.st[i] = BK_IDLE;
                    default: next_cur.st[i] = cur.st[i];
                endcase
            end
        end
        if (cur.rd_live && next_cur.st[cur.last_rd_bank] != BK_READ
            && next_cur.st[cur.last_rd_bank] != BK_READ_AP)
            next_cur.rd_live = 1'b0;
        // Device-wide busy ends, all banks idle
        if (cur.dev != DEV_READY && cur.dev_tmr <= ONE_T)
        begin
            next_cur.dev = DEV_READY;
            for (int i = 0; i < NUM_BANKS; i++)
                next_cur.st[i] = BK_IDLE;
        end
        // ************************************
        // Command legality and acceptance
        // ************************************
        // Checks only with clock enable high on both edges
        if (!(cur.cke_prev && cmd_bus.cke))
            ok = 1'b0;
        else if (cmd == CMD_DESELECT || cmd == CMD_NOP)
            ok = 1'b0;
        else if (cur.dev != DEV_READY)
            ok = 1'b0;
        else
        begin
            case (cmd)
                // Own bank state decides; other banks block only through the AP gap timers and, for writes, a live read
                CMD_ACTIVE:
                    ok = (cur.st[b] == BK_IDLE) && (cur.gap_pa <= ONE_T);
                CMD_READ:
                    ok = (cur.st[b] == BK_ROW_ACTIVE || cur.st[b] == BK_READ
                          || cur.st[b] == BK_WRITE) && (cur.gap_rd <= ONE_T);
                CMD_WRITE:
                    // No write over a live read burst
                    ok = (cur.st[b] == BK_ROW_ACTIVE || cur.st[b] == BK_WRITE)
                         && !cur.rd_live && (cur.gap_wr <= ONE_T);
                CMD_PRECHARGE:
                begin
                    // Each targeted bank must allow precharge
                    if (cmd_bus.all_banks)
                    begin
                        for (int i = 0; i < NUM_BANKS; i++)
                            if (cur.st[i] == BK_ACTIVATING || cur.st[i] == BK_READ_AP
                                || cur.st[i] == BK_WRITE_AP)
                                ok = 1'b0;
                    end
                    else
                        ok = cur.st[b] != BK_ACTIVATING && cur.st[b] != BK_READ_AP
                             && cur.st[b] != BK_WRITE_AP;
                    if (cur.gap_pa > ONE_T)
                        ok = 1'b0;
                end
                // Needs some read burst to end
                CMD_BURST_STOP: ok = cur.rd_live;
                // Whole-device commands need all banks idle
                CMD_REFRESH, CMD_LOAD_MODE: ok = !any_busy;
                default: ok = 1'b0;
            endcase
        end

        // Flag any executable command that breaks state or timing
        next_cur.illegal = !ok && cmd != CMD_DESELECT && cmd != CMD_NOP;
        next_cur.accepted = ok;
        if (ok)
        begin
            case (cmd)
                CMD_ACTIVE:
                begin
                    next_cur.st[b] = BK_ACTIVATING;
                    next_cur.tmr[b] = RCD_T;
                end
                CMD_READ:
                begin
                    next_cur.last_rd_bank = b;
                    next_cur.rd_live = 1'b1;
                    if (cmd_bus.auto_pre)
                    begin
                        // Access until earliest precharge slot, then tRP
                        next_cur.st[b] = BK_READ_AP;
                        next_cur.acc[b] = BURST_CK;
                        next_cur.tmr[b] = BURST_CK + RP_T;
                        // Other-bank gaps after read auto precharge
                        next_cur.gap_rd = maxt(next_cur.gap_rd, BURST_CK);
                        next_cur.gap_wr = maxt(next_cur.gap_wr, CL_T + BURST_CK);
                        next_cur.gap_pa = maxt(next_cur.gap_pa, ONE_T);
                    end
                    else
                    begin
                        next_cur.st[b] = BK_READ;
                        next_cur.tmr[b] = BURST_CK;
                    end
                end
                CMD_WRITE:
                begin
                    if (cmd_bus.auto_pre)
                    begin
                        next_cur.st[b] = BK_WRITE_AP;
                        next_cur.acc[b] = BURST_CK + WR_T;
                        next_cur.tmr[b] = BURST_CK + WR_T + RP_T;
                        // Other-bank gaps after write auto precharge
                        next_cur.gap_rd = maxt(next_cur.gap_rd, ONE_T + BURST_CK + WTR_T);
                        next_cur.gap_wr = maxt(next_cur.gap_wr, BURST_CK);
                        next_cur.gap_pa = maxt(next_cur.gap_pa, ONE_T);
                    end
                    else
                    begin
                        next_cur.st[b] = BK_WRITE;
                        next_cur.tmr[b] = BURST_CK;
                    end
                end
                CMD_PRECHARGE:
                begin
                    if (cmd_bus.all_banks)
                    begin
                        next_cur.dev = DEV_PRECHARGE_ALL;
                        next_cur.dev_tmr = RP_T;
                        for (int i = 0; i < NUM_BANKS; i++)
                            next_cur.st[i] = BK_PRECHARGING;
                    end
                    else
                    begin
                        next_cur.st[b] = BK_PRECHARGING;
                        next_cur.tmr[b] = RP_T;
                    end
                end
                CMD_BURST_STOP:
                begin
                    // Most recent read, plain reads only back to row active
                    if (cur.st[cur.last_rd_bank] == BK_READ)
                        next_cur.st[cur.last_rd_bank] = BK_ROW_ACTIVE;
                    next_cur.rd_live = 1'b0;
                end
                CMD_REFRESH, CMD_LOAD_MODE:
                begin
                    next_cur.dev = (cmd == CMD_REFRESH) ? DEV_REFRESHING : DEV_MODE_ACCESS;
                    next_cur.dev_tmr = (cmd == CMD_REFRESH) ? RFC_T : MRD_T;
                end
                default: ;
            endcase
        end
    end
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            cur <= '0;
        else
            cur <= next_cur;
    end
    // ************************************
    // Outputs
    // ************************************
    always_comb
    begin
        all_idle = (cur.dev == DEV_READY);
        for (int i = 0; i < NUM_BANKS; i++)
        begin
            bank_view[i].state = cur.st[i];
            bank_view[i].timer = cur.tmr[i];
            if (cur.st[i] != BK_IDLE)
                all_idle = 1'b0;
        end
    end

    assign dev_state = cur.dev;
    assign cmd_illegal = cur.illegal;
    assign cmd_accepted = cur.accepted;
endmodule // lbc_bank_legality
`default_nettype wire

// >>> dv/lbc_legality_chk.sv
`default_nettype none
module lbc_legality_chk
    import lbc_pkg::*;
#(
    parameter int BL = 4,
    parameter int CL = 3
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire lbc_pkg::lbc_cmd_bus_t cmd_bus,
    input wire lbc_pkg::lbc_bank_t bank_view [lbc_pkg::NUM_BANKS],
    input wire lbc_pkg::lbc_dev_state_t dev_state,
    input wire logic all_idle,
    input wire logic cmd_illegal,
    input wire logic cmd_accepted
);
    // ****
    // Strobe decode
    // ****
    logic sel;
    logic quiet;
    assign sel = cmd_bus.cke && !cmd_bus.cs_n;
    assign quiet = cmd_bus.cs_n || (cmd_bus.ras_n && cmd_bus.cas_n && cmd_bus.we_n);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    chk_flag_excl: assert property (!(cmd_illegal && cmd_accepted))
        else $error("accepted and illegal together");
    chk_nop_quiet: assert property (quiet |=> !cmd_accepted && !cmd_illegal)
        else $error("flag after deselect or nop");
    chk_busy_refuse: assert property ((dev_state != DEV_READY) && sel && !quiet |=> cmd_illegal)
        else $error("command taken while device busy");
    chk_refresh_enter: assert property (sel && {cmd_bus.ras_n, cmd_bus.cas_n, cmd_bus.we_n} == 3'b001
        ##1 cmd_accepted |-> dev_state == DEV_REFRESHING)
        else $error("refresh did not start");
    chk_mode_enter: assert property (sel && {cmd_bus.ras_n, cmd_bus.cas_n, cmd_bus.we_n} == 3'b000
        ##1 cmd_accepted |-> dev_state == DEV_MODE_ACCESS)
        else $error("mode access did not start");
    chk_preall_enter: assert property (sel && cmd_bus.all_banks
        && {cmd_bus.ras_n, cmd_bus.cas_n, cmd_bus.we_n} == 3'b010
        ##1 cmd_accepted |-> dev_state == DEV_PRECHARGE_ALL)
        else $error("precharge all did not start");
    chk_busy_bound: assert property (dev_state != DEV_READY |-> ##[1:4] dev_state == DEV_READY)
        else $error("device busy too long");
    chk_busy_idle: assert property ((dev_state != DEV_READY) ##1 (dev_state == DEV_READY)
        |-> all_idle)
        else $error("banks not idle after busy");
    chk_cke_gate: assert property (!cmd_bus.cke |=> !cmd_accepted [*2])
        else $error("accepted without clock enable");
    for (genvar g = 0; g < NUM_BANKS; g++)
    begin : g_bank
        chk_rdap_end: assert property (bank_view[g].state == BK_READ_AP
            |-> ##[1:12] bank_view[g].state == BK_IDLE)
            else $error("read auto precharge never ends");
        chk_wrap_end: assert property (bank_view[g].state == BK_WRITE_AP
            |-> ##[1:12] bank_view[g].state == BK_IDLE)
            else $error("write auto precharge never ends");
    end
endmodule // lbc_legality_chk

bind lbc_bank_legality lbc_legality_chk #(.BL(BL), .CL(CL)) lbc_legality_chk_i (
    .core_clk(core_clk),
    .rst(rst),
    .cmd_bus(cmd_bus),
    .bank_view(bank_view),
    .dev_state(dev_state),
    .all_idle(all_idle),
    .cmd_illegal(cmd_illegal),
    .cmd_accepted(cmd_accepted)
);
`default_nettype wire

// >>> dv/lbc_ctl_model.sv
`default_nettype none
module lbc_ctl_model
    import lbc_pkg::*;
(
    input wire logic core_clk,
    output var lbc_pkg::lbc_cmd_bus_t cmd_bus
);
    timeunit 1ns;
    timeprecision 1ns;
    initial cmd_bus = 9'h1f0;

    // ****
    // Command drive, caller sits at a falling edge
    // ****
    // order is chosen by the caller
    task automatic put(input lbc_cmd_t c, input logic [1:0] b, input logic ap,
                       input logic ck);
        logic [2:0] rcw;
        case (c)
            CMD_ACTIVE: rcw = 3'b011;
            CMD_READ: rcw = 3'b101;
            CMD_WRITE: rcw = 3'b100;
            CMD_PRECHARGE: rcw = 3'b010;
            CMD_BURST_STOP: rcw = 3'b110;
            CMD_REFRESH: rcw = 3'b001;
            CMD_LOAD_MODE: rcw = 3'b000;
            default: rcw = 3'b111;
        endcase
        cmd_bus.cke = ck;
        cmd_bus.cs_n = (c == CMD_DESELECT);
        {cmd_bus.ras_n, cmd_bus.cas_n, cmd_bus.we_n} = rcw;
        // Bank lines flip on NOP and deselect so no stale value looks meaningful
        cmd_bus.bank = (rcw == 3'b111) ? ~cmd_bus.bank : b;
        cmd_bus.auto_pre = ap && (c != CMD_PRECHARGE);
        cmd_bus.all_banks = ap && (c == CMD_PRECHARGE);
    endtask
endmodule // lbc_ctl_model
`default_nettype wire

// >>> dv/lbc_bank_legality_tb.sv
`default_nettype none
module lbc_bank_legality_tb
    import lbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk;
    logic rst;
    lbc_cmd_bus_t cmd_bus;
    lbc_bank_t bank_view [NUM_BANKS];
    lbc_dev_state_t dev_state;
    logic all_idle;
    logic cmd_illegal;
    logic cmd_accepted;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;

    lbc_ctl_model lbc_ctl_model_i (.core_clk(core_clk), .cmd_bus(cmd_bus));
    lbc_bank_legality lbc_bank_legality_i (
        .core_clk(core_clk),
        .rst(rst),
        .cmd_bus(cmd_bus),
        .bank_view(bank_view),
        .dev_state(dev_state),
        .all_idle(all_idle),
        .cmd_illegal(cmd_illegal),
        .cmd_accepted(cmd_accepted)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // ****
    // Shared tasks
    // ****
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Drive at this falling edge, judge the flags one cycle on
    task automatic issue(input lbc_cmd_t c, input logic [1:0] b, input logic ap,
                         input logic ck, input logic ok);
        lbc_ctl_model_i.put(c, b, ap, ck);
        @(negedge core_clk);
        check("accepted", cmd_accepted, ok);
        check("illegal", cmd_illegal, !ok);
    endtask

    task automatic nop(input int n);
        lbc_ctl_model_i.put(CMD_NOP, 2'h0, 1'b0, 1'b1);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic bst(input int b, input lbc_bank_state_t s);
        check("bank state", bank_view[b].state, s);
    endtask

    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        for (int b = 0; b < NUM_BANKS; b++)
            bst(b, BK_IDLE);
        check("dev", dev_state, DEV_READY);
        check("all idle", all_idle, 1'b1);
        rst = 1'b0;
        // Clock enable history is low out of reset
        issue(CMD_ACTIVE, 2'h0, 1'b0, 1'b1, 1'b0);
        nop(1);
        bst(0, BK_IDLE);
    endtask

    task automatic t_read_ap();
        issue(CMD_ACTIVE, 2'h0, 1'b0, 1'b1, 1'b1);
        bst(0, BK_ACTIVATING);
        issue(CMD_ACTIVE, 2'h0, 1'b0, 1'b1, 1'b0);
        bst(0, BK_ROW_ACTIVE);
        issue(CMD_READ, 2'h0, 1'b1, 1'b1, 1'b1);
        bst(0, BK_READ_AP);
        check("timer", bank_view[0].timer, 8'(BURST_LEN / 2 + RP_CK));
        // One cycle after the AP read is the earliest other-bank activate
        issue(CMD_ACTIVE, 2'h1, 1'b0, 1'b1, 1'b1);
        nop(1);
        bst(0, BK_READ_AP);
        nop(1);
        bst(0, BK_IDLE);
        bst(1, BK_ROW_ACTIVE);
    endtask

    task automatic t_write_ap();
        issue(CMD_ACTIVE, 2'h0, 1'b0, 1'b1, 1'b1);
        nop(1);
        issue(CMD_WRITE, 2'h0, 1'b1, 1'b1, 1'b1);
        bst(0, BK_WRITE_AP);
        issue(CMD_READ, 2'h1, 1'b0, 1'b1, 1'b0);
        issue(CMD_ACTIVE, 2'h2, 1'b0, 1'b1, 1'b1);
        // Other-bank read frees at 1 + BL/2 + tWTR cycles, one short is refused
        issue(CMD_READ, 2'h1, 1'b0, 1'b1, 1'b0);
        bst(0, BK_WRITE_AP);
        issue(CMD_READ, 2'h1, 1'b0, 1'b1, 1'b1);
        bst(0, BK_IDLE);
    endtask

    task automatic t_burst();
        issue(CMD_READ, 2'h1, 1'b0, 1'b1, 1'b1);
        bst(1, BK_READ);
        issue(CMD_WRITE, 2'h1, 1'b0, 1'b1, 1'b0);
        issue(CMD_READ, 2'h1, 1'b0, 1'b1, 1'b1);
        issue(CMD_BURST_STOP, 2'h3, 1'b0, 1'b1, 1'b1);
        issue(CMD_WRITE, 2'h1, 1'b0, 1'b1, 1'b1);
        bst(1, BK_WRITE);
        nop(4);
        issue(CMD_BURST_STOP, 2'h1, 1'b0, 1'b1, 1'b0);
        issue(CMD_PRECHARGE, 2'h1, 1'b0, 1'b1, 1'b1);
        bst(1, BK_PRECHARGING);
    endtask

    task automatic t_device();
        lbc_cmd_t ops [3] = '{CMD_PRECHARGE, CMD_REFRESH, CMD_LOAD_MODE};
        lbc_dev_state_t devs [3] = '{DEV_PRECHARGE_ALL, DEV_REFRESHING, DEV_MODE_ACCESS};
        issue(CMD_REFRESH, 2'h0, 1'b0, 1'b1, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            issue(ops[i], 2'h0, i == 0, 1'b1, 1'b1);
            check("dev", dev_state, devs[i]);
            issue(CMD_ACTIVE, 2'h3, 1'b0, 1'b1, 1'b0);
            nop(3);
            check("dev", dev_state, DEV_READY);
            check("all idle", all_idle, 1'b1);
        end
    endtask

    task automatic t_cke();
        issue(CMD_ACTIVE, 2'h0, 1'b0, 1'b0, 1'b0);
        issue(CMD_ACTIVE, 2'h0, 1'b0, 1'b1, 1'b0);
        issue(CMD_ACTIVE, 2'h0, 1'b0, 1'b1, 1'b1);
        lbc_ctl_model_i.put(CMD_DESELECT, 2'h0, 1'b0, 1'b1);
        @(negedge core_clk);
        check("deselect accepted", cmd_accepted, 1'b0);
        check("deselect illegal", cmd_illegal, 1'b0);
        nop(2);
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    initial
    begin
        rst = 1'b1;
        repeat (10) @(negedge core_clk);
        t_reset();
        t_read_ap();
        t_write_ap();
        t_burst();
        t_device();
        t_cke();
        tally_and_finish();
    end
endmodule // lbc_bank_legality_tb
`default_nettype wire
